// file: pkg/uact_cfg.svh
// Purpose: addresses, field positions, reset values and counts of the uart block
// Assumes: 32-bit aligned registers, low byte carries all fields
// Notes: every figure of the block lives here once
`ifndef UACT_CFG_SVH
`define UACT_CFG_SVH
// register byte addresses
`define UACT_RBR_ADDR 32'h40008000
`define UACT_IER_ADDR 32'h40008004
`define UACT_FCR_ADDR 32'h40008008
`define UACT_MCR_ADDR 32'h40008010
`define UACT_LSR_ADDR 32'h40008014
`define UACT_MSR_ADDR 32'h40008018
`define UACT_MSC_ADDR 32'h4000801C
`define UACT_ER_ADDR 32'h40008024
// field positions
`define UACT_IER_CTS 7
`define UACT_MCR_AUTO_CLEAR_TO_SEND_ENABLE 7
`define UACT_ER_MS 3
`define UACT_FCR_EN 0
`define UACT_LSR_RDR 0
`define UACT_LSR_OE 1
`define UACT_LSR_PE 2
`define UACT_MSR_DCTS 0
// reset values
`define UACT_REG_RST 8'h00
`define UACT_PIN_RST 4'hF
// counts and responses
`define UACT_BIT_CYC 16
`define UACT_FIFO_DEPTH 16
`define UACT_RESP_OK 2'h0
`define UACT_RESP_ERR 2'h2
`endif

// file: pkg/uact_pkg.sv
// Purpose: shared types of the uart block
// Assumes: nothing beyond the cfg header
// Notes: state codes written out
package uact_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_START = 2'h1,
		TX_DATA = 2'h2,
		TX_STOP = 2'h3
	} uact_tx_t;
endpackage : uact_pkg

// file: design/uact_sync.sv
// Purpose: two-stage level synchroniser for modem pins
// Assumes: inputs are levels, settle for two clocks
// Notes: first stage feeds only the second
module uact_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST = '1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// two flops in a row, nothing taps the first
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_r <= RST;
			q <= RST;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : uact_sync

// file: design/uact_fifo.sv
// Purpose: small fifo with registered head word
// Assumes: DEPTH is a power of two
// Notes: head data valid in the cycle rd_valid is high
module uact_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, rp_r, rp_nxt;
	logic [AW:0] cnt_r;
	logic push, pop;

	assign wr_ready = cnt_r != (AW+1)'(DEPTH);
	assign rd_valid = cnt_r != '0;
	assign push = wr_valid && wr_ready;
	assign pop = rd_ready && rd_valid;
	assign rp_nxt = rp_r + AW'(pop);

	// storage and pointers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			wp_r <= wp_r + AW'(push);
			rp_r <= rp_nxt;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wp_r] <= wr_data;
		end
	end

	// head register, bypass when the head slot is written now
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_data <= '0;
		end else if (ce) begin
			rd_data <= (push && wp_r == rp_nxt) ? wr_data : mem[rp_nxt];
		end
	end
endmodule : uact_fifo

// file: design/uact_top.sv
// Purpose: uart transmit with hardware cts gating, modem and line status
// Assumes: 8N1 transmit, receive shifter outside hands over whole characters
// Notes: registers over AXI4-Lite, one register per aligned word
//
// Overview of operation
// - cts gating only while auto-cts enable set
// - cts sampled before each next character start
// - cts low permits start, high withholds it
// - deassert mid-character finishes it, then stall
// - stalled transmitter drives idle mark level
// - resume sends start bit then next data
// - auto-cts off sends queued data regardless
// - every cts change sets delta-cts flag
// - master enable low blocks modem interrupt
// - with auto-cts, delta-cts needs cts enable
// - data ready while receive buffer nonempty
// - line status read clears overrun
// - bad parity sets flag, read clears
// - parity flag follows fifo head character
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "uact_cfg.svh"
module uact_top #(
	parameter int BIT_CYC = `UACT_BIT_CYC,
	parameter int DEPTH = `UACT_FIFO_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic dcd_n,
	output logic txd,
	input wire logic rsh_valid,
	input wire logic [7:0] rsh_data,
	input wire logic rsh_parity_bad,
	output logic irq
);
	localparam int CW = $clog2(BIT_CYC);

	logic [31:0] awaddr_r, wdata_r;
	logic wb0_r, do_wr, rd_hs, lsr_rd, mapped_w, mapped_r;
	logic [7:0] ier_r, fcr_r, mcr_r, er_r, rd_mux;
	logic [3:0] pins_s, pins_prev_r, ms_set, ms_r, ms_clr;
	logic cts_en, cts_low, fifo_en;
	logic tx_push, tx_wr_ready, tx_rd_valid, tx_go;
	logic [7:0] tx_head;
	uact_pkg::uact_tx_t tx_state_r;
	logic [CW-1:0] cyc_r;
	logic [2:0] bit_r;
	logic [7:0] shift_r;
	logic bit_end;
	logic rx_push, rx_pop, rx_wr_ready, rx_rd_valid, rx_full;
	logic [8:0] rx_head;
	logic oe_r, pe_r, pe_seen_r, oe_set, pe_set;

	assign cts_en = mcr_r[`UACT_MCR_AUTO_CLEAR_TO_SEND_ENABLE];
	assign fifo_en = fcr_r[`UACT_FCR_EN];
	assign cts_low = !pins_s[0];
	assign do_wr = !awready && !wready && !bvalid;
	assign rd_hs = arvalid && arready;
	assign lsr_rd = rd_hs && araddr == `UACT_LSR_ADDR;

	// pins order {dcd, ri, dsr, cts}, all through two flops
	uact_sync #(
		.W(4),
		.RST(`UACT_PIN_RST)
	) u_sync (
		.clk(aclk),
		.rstn(aresetn),
		.ce(ce),
		.d({dcd_n, ri_n, dsr_n, cts_n}),
		.q(pins_s)
	);

	// write address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			awaddr_r <= '0;
			wdata_r <= '0;
			wb0_r <= 1'b0;
		end else if (ce) begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awaddr_r <= awaddr;
			end else if (do_wr) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wdata_r <= wdata;
				wb0_r <= wstrb[0];
			end else if (do_wr) begin
				wready <= 1'b1;
			end
		end
	end

	always_comb begin
		unique case (awaddr_r)
			`UACT_RBR_ADDR, `UACT_IER_ADDR, `UACT_FCR_ADDR, `UACT_MCR_ADDR,
			`UACT_MSC_ADDR, `UACT_ER_ADDR: mapped_w = 1'b1;
			default: mapped_w = 1'b0;
		endcase
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `UACT_RESP_OK;
		end else if (ce) begin
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp <= mapped_w ? `UACT_RESP_OK : `UACT_RESP_ERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// software control registers, low byte lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ier_r <= `UACT_REG_RST;
			fcr_r <= `UACT_REG_RST;
			mcr_r <= `UACT_REG_RST;
			er_r <= `UACT_REG_RST;
		end else if (ce && do_wr && wb0_r) begin
			unique case (awaddr_r)
				`UACT_IER_ADDR: ier_r <= wdata_r[7:0];
				`UACT_FCR_ADDR: fcr_r <= wdata_r[7:0];
				`UACT_MCR_ADDR: mcr_r <= wdata_r[7:0];
				`UACT_ER_ADDR: er_r <= wdata_r[7:0];
				default: ;
			endcase
		end
	end

	// read mux
	always_comb begin
		mapped_r = 1'b1;
		unique case (araddr)
			`UACT_RBR_ADDR: rd_mux = rx_head[7:0];
			`UACT_IER_ADDR: rd_mux = ier_r;
			`UACT_FCR_ADDR: rd_mux = fcr_r;
			`UACT_MCR_ADDR: rd_mux = mcr_r;
			`UACT_LSR_ADDR: rd_mux = {5'h00, pe_r, oe_r, rx_rd_valid};
			`UACT_MSR_ADDR: rd_mux = {~pins_s, ms_r};
			`UACT_ER_ADDR: rd_mux = er_r;
			default: begin
				rd_mux = 8'h00;
				mapped_r = 1'b0;
			end
		endcase
		if (araddr == `UACT_RBR_ADDR && !rx_rd_valid) begin
			rd_mux = 8'h00;
		end
	end

	// read channel, one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `UACT_RESP_OK;
		end else if (ce) begin
			if (rd_hs) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h000000, rd_mux};
				rresp <= mapped_r ? `UACT_RESP_OK : `UACT_RESP_ERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// modem deltas: changes of cts, dsr, dcd and trailing edge of ri
	assign ms_set = {pins_s[3] ^ pins_prev_r[3], pins_s[2] && !pins_prev_r[2],
		pins_s[1] ^ pins_prev_r[1], pins_s[0] ^ pins_prev_r[0]};
	assign ms_clr = (do_wr && wb0_r && awaddr_r == `UACT_MSC_ADDR) ? wdata_r[3:0] : 4'h0;

	// sticky modem flags, a set beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_prev_r <= `UACT_PIN_RST;
			ms_r <= 4'h0;
		end else if (ce) begin
			pins_prev_r <= pins_s;
			ms_r <= ms_set | (ms_r & ~ms_clr);
		end
	end

	// modem interrupt qualification
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= er_r[`UACT_ER_MS] && ((|ms_r[3:1]) ||
				(ms_r[0] && (!cts_en || ier_r[`UACT_IER_CTS])));
		end
	end

	// transmit queue, full queue drops the write
	assign tx_push = do_wr && wb0_r && awaddr_r == `UACT_RBR_ADDR;
	assign tx_go = tx_state_r == uact_pkg::TX_IDLE && tx_rd_valid &&
		(!cts_en || cts_low);
	assign bit_end = cyc_r == CW'(BIT_CYC - 1);

	uact_fifo #(
		.W(8),
		.DEPTH(DEPTH)
	) u_txq (
		.clk(aclk),
		.rstn(aresetn),
		.ce(ce),
		.wr_valid(tx_push),
		.wr_ready(tx_wr_ready),
		.wr_data(wdata_r[7:0]),
		.rd_valid(tx_rd_valid),
		.rd_ready(tx_go),
		.rd_data(tx_head)
	);

	// bit timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_r <= '0;
		end else if (ce) begin
			if (tx_go || bit_end || tx_state_r == uact_pkg::TX_IDLE) begin
				cyc_r <= '0;
			end else begin
				cyc_r <= cyc_r + CW'(1);
			end
		end
	end

	// transmit shifter: start, eight data lsb first, one stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_r <= uact_pkg::TX_IDLE;
			txd <= 1'b1;
			shift_r <= 8'h00;
			bit_r <= 3'h0;
		end else if (ce) begin
			unique case (tx_state_r)
				uact_pkg::TX_IDLE: begin
					txd <= 1'b1;
					if (tx_go) begin
						tx_state_r <= uact_pkg::TX_START;
						txd <= 1'b0;
						shift_r <= tx_head;
					end
				end
				uact_pkg::TX_START: begin
					if (bit_end) begin
						tx_state_r <= uact_pkg::TX_DATA;
						txd <= shift_r[0];
						bit_r <= 3'h0;
					end
				end
				uact_pkg::TX_DATA: begin
					if (bit_end) begin
						if (bit_r == 3'h7) begin
							tx_state_r <= uact_pkg::TX_STOP;
							txd <= 1'b1;
						end else begin
							bit_r <= bit_r + 3'h1;
							shift_r <= {1'b0, shift_r[7:1]};
							txd <= shift_r[1];
						end
					end
				end
				uact_pkg::TX_STOP: begin
					if (bit_end) begin
						tx_state_r <= uact_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

	// receive buffer, depth one when fifo mode is off
	assign rx_full = fifo_en ? !rx_wr_ready : rx_rd_valid;
	assign rx_push = rsh_valid && !rx_full;
	assign rx_pop = rd_hs && araddr == `UACT_RBR_ADDR && rx_rd_valid;
	assign oe_set = rsh_valid && rx_full;
	assign pe_set = fifo_en ? (rx_rd_valid && rx_head[8] && !pe_seen_r) :
		(rx_push && rsh_parity_bad);

	uact_fifo #(
		.W(9),
		.DEPTH(DEPTH)
	) u_rxq (
		.clk(aclk),
		.rstn(aresetn),
		.ce(ce),
		.wr_valid(rx_push),
		.wr_ready(rx_wr_ready),
		.wr_data({rsh_parity_bad, rsh_data}),
		.rd_valid(rx_rd_valid),
		.rd_ready(rx_pop),
		.rd_data(rx_head)
	);

	// line status flags, a set beats the read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oe_r <= 1'b0;
			pe_r <= 1'b0;
			pe_seen_r <= 1'b0;
		end else if (ce) begin
			oe_r <= oe_set || (oe_r && !lsr_rd);
			pe_r <= pe_set || (pe_r && !lsr_rd);
			pe_seen_r <= !rx_pop && (pe_seen_r || rx_rd_valid);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	property p_no_gate;
		tx_state_r == uact_pkg::TX_IDLE && tx_rd_valid && !cts_en |=>
			tx_state_r == uact_pkg::TX_START;
	endproperty
	a_no_gate: assert property (p_no_gate) else $error("queued data not sent");

	property p_hold;
		tx_state_r == uact_pkg::TX_IDLE && cts_en && !cts_low |=>
			tx_state_r == uact_pkg::TX_IDLE;
	endproperty
	a_hold: assert property (p_hold) else $error("started with cts high");

	property p_mark;
		tx_state_r == uact_pkg::TX_IDLE && $past(tx_state_r) == uact_pkg::TX_IDLE |-> txd;
	endproperty
	a_mark: assert property (p_mark) else $error("idle line not marking");

	property p_resume;
		tx_go |=> !txd [*2] ##0 tx_state_r == uact_pkg::TX_START;
	endproperty
	a_resume: assert property (p_resume) else $error("no start bit");

	property p_finish;
		tx_state_r == uact_pkg::TX_DATA |=> tx_state_r != uact_pkg::TX_IDLE;
	endproperty
	a_finish: assert property (p_finish) else $error("character cut short");

	property p_dcts;
		pins_s[0] != pins_prev_r[0] |=> ms_r[0];
	endproperty
	a_dcts: assert property (p_dcts) else $error("delta cts lost");

	property p_master;
		irq |-> $past(er_r[`UACT_ER_MS]);
	endproperty
	a_master: assert property (p_master) else $error("irq without master enable");

	property p_ctsint;
		irq && $past(cts_en && !ier_r[`UACT_IER_CTS]) |-> $past(|ms_r[3:1]);
	endproperty
	a_ctsint: assert property (p_ctsint) else $error("delta cts raised irq");

	property p_rdr;
		rd_hs && araddr == `UACT_LSR_ADDR |=> rdata[0] == $past(rx_rd_valid);
	endproperty
	a_rdr: assert property (p_rdr) else $error("data ready wrong");

	property p_oe;
		rsh_valid && rx_full |=> oe_r && rx_head == $past(rx_head);
	endproperty
	a_oe: assert property (p_oe) else $error("overrun missed");

	property p_oe_clr;
		lsr_rd && !oe_set |=> !oe_r;
	endproperty
	a_oe_clr: assert property (p_oe_clr) else $error("overrun not cleared");

	property p_pe;
		!fifo_en && rx_push && rsh_parity_bad |=> pe_r;
	endproperty
	a_pe: assert property (p_pe) else $error("parity error missed");

	property p_pe_head;
		fifo_en && rx_rd_valid && rx_head[8] && !pe_seen_r |=> pe_r;
	endproperty
	a_pe_head: assert property (p_pe_head) else $error("head parity missed");

	property p_sync;
		$past(ce) && $past(ce, 2) |-> pins_s[0] == $past(cts_n, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("cts sync latency");

	c_stall: cover property (tx_state_r == uact_pkg::TX_IDLE && tx_rd_valid && cts_en &&
		!cts_low ##1 tx_go);
	c_overrun: cover property (oe_set);
	c_irq: cover property (!irq ##1 irq);
endmodule : uact_top

// file: testbench/uact_remote.sv
// Purpose: remote uart model, drives cts and decodes the serial stream
// Assumes: 8N1 framing, bit time of BIT_CYC clocks
// Notes: cts follows the hold request one clock later
module uact_remote #(
	parameter int BIT_CYC = 4
) (
	input wire logic aclk,
	input wire logic hold,
	input wire logic txd,
	output logic cts_n,
	output logic [7:0] rx_byte,
	output int rx_cnt,
	output int bad_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// pause request raised well before the last stop bit
	initial cts_n = 1'h1;
	always @(posedge aclk) cts_n <= hold;
	// sample each bit in its middle, count bad framing
	initial begin
		rx_cnt = 0;
		bad_cnt = 0;
		rx_byte = 8'h00;
		forever begin
			@(negedge txd);
			repeat (BIT_CYC / 2) @(posedge aclk);
			if (txd !== 1'h0) bad_cnt++;
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge aclk);
				rx_byte[i] = txd;
			end
			repeat (BIT_CYC) @(posedge aclk);
			if (txd !== 1'h1) bad_cnt++;
			rx_cnt++;
		end
	end
endmodule : uact_remote

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the uart flow control and status block
// Assumes: short bit time and fifo depth through parameters
// Notes: random bytes from a fixed seed
`include "uact_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BC = 4;
	localparam int DP = 4;
	logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, cts_n, dsr_n, ri_n, dcd_n, txd;
	logic rsh_valid, rsh_parity_bad, irq, hold;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] rsh_data, rx_byte;
	int rx_cnt, bad_cnt, err_total, total_checks;
	uact_top #(.BIT_CYC(BC), .DEPTH(DP)) uut (.aclk, .aresetn, .ce, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cts_n, .dsr_n, .ri_n,
		.dcd_n, .txd, .rsh_valid, .rsh_data, .rsh_parity_bad, .irq);
	uact_remote #(.BIT_CYC(BC)) remote (.aclk, .hold, .txd, .cts_n, .rx_byte, .rx_cnt,
		.bad_cnt);
	// 250 MHz clock
	always #2 aclk = ~aclk;
	task automatic end_of_test();
		if (err_total == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tmo(input string nm);
		err_total++;
		$display("FAIL %s expected done seen timeout", nm);
		end_of_test();
	endtask : tmo
	function automatic logic [31:0] msr(input logic [3:0] d, input logic [3:0] a);
		return {24'h000000, a, d};
	endfunction : msr
	function automatic logic [31:0] lsr(input logic dr, input logic oe, input logic pe);
		return {29'h00000000, pe, oe, dr};
	endfunction : lsr
	// bus write, address and data offered together
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
			input logic [1:0] er = `UACT_RESP_OK);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && n < 40);
		bready <= 1'h0;
		if (n >= 40) tmo("write");
		chk("bresp", bresp, er);
	endtask : wr
	// bus read compared with expectation
	task automatic rdc(input logic [31:0] a, input logic [31:0] e,
			input logic [1:0] er = `UACT_RESP_OK);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && n < 40);
		rready <= 1'h0;
		if (n >= 40) tmo("read");
		chk($sformatf("rdata %h", a), rdata, e);
		chk("rresp", rresp, er);
	endtask : rdc
	task automatic push(input logic [7:0] b, input logic bad);
		@(posedge aclk);
		rsh_valid <= 1'h1;
		rsh_data <= b;
		rsh_parity_bad <= bad;
		@(posedge aclk);
		rsh_valid <= 1'h0;
	endtask : push
	task automatic wait_rx(input int c);
		int n;
		n = 0;
		while (rx_cnt < c && n < 100 * BC) begin
			@(posedge aclk);
			n++;
		end
		if (rx_cnt < c) tmo("serial");
	endtask : wait_rx
	task automatic pulse_cts();
		hold <= 1'h0;
		repeat (8) @(posedge aclk);
		hold <= 1'h1;
		repeat (8) @(posedge aclk);
	endtask : pulse_cts
	// main sequence
	initial begin
		logic [7:0] q[$];
		logic [7:0] b, b2;
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{rsh_valid, rsh_parity_bad, rsh_data, awaddr, wdata, araddr} = '0;
		{ce, hold, dsr_n, ri_n, dcd_n} = 5'h1F;
		wstrb = 4'hF;
		err_total = 0;
		total_checks = 0;
		void'($urandom(73465));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rdc(`UACT_LSR_ADDR, 32'h0);
		rdc(`UACT_MSR_ADDR, 32'h0);
		rdc(32'h40008030, 32'h0, `UACT_RESP_ERR);
		// read-only line status refuses a write and keeps its flags
		wr(`UACT_LSR_ADDR, 32'hFF, `UACT_RESP_ERR);
		rdc(`UACT_LSR_ADDR, 32'h0);
		chk("txd", txd, 1'h1);
		// auto cts off: sends although cts is high
		b = 8'($urandom);
		wr(`UACT_RBR_ADDR, {24'h0, b});
		wait_rx(1);
		chk("rx byte", rx_byte, b);
		// modem status interrupt
		wr(`UACT_ER_ADDR, 32'h08);
		hold <= 1'h0;
		repeat (8) @(posedge aclk);
		rdc(`UACT_MSR_ADDR, msr(4'h1, 4'h1));
		chk("irq", irq, 1'h1);
		wr(`UACT_MSC_ADDR, 32'h0F);
		repeat (2) @(posedge aclk);
		chk("irq", irq, 1'h0);
		wr(`UACT_MCR_ADDR, 32'h80);
		hold <= 1'h1;
		repeat (8) @(posedge aclk);
		rdc(`UACT_MSR_ADDR, msr(4'h1, 4'h0));
		chk("irq", irq, 1'h0);
		wr(`UACT_IER_ADDR, 32'h80);
		repeat (2) @(posedge aclk);
		chk("irq", irq, 1'h1);
		// low byte lane off: enable register keeps its value
		wstrb <= 4'hE;
		wr(`UACT_IER_ADDR, 32'h00);
		wstrb <= 4'hF;
		rdc(`UACT_IER_ADDR, 32'h80);
		chk("irq", irq, 1'h1);
		wr(`UACT_MSC_ADDR, 32'h0F);
		for (int k = 0; k < 3; k++) begin
			{dcd_n, ri_n, dsr_n} <= ~(3'h1 << k);
			repeat (8) @(posedge aclk);
			{dcd_n, ri_n, dsr_n} <= 3'h7;
			repeat (8) @(posedge aclk);
			rdc(`UACT_MSR_ADDR, msr(4'h2 << k, 4'h0));
			chk("irq", irq, 1'h1);
			wr(`UACT_MSC_ADDR, 32'h0F);
			repeat (2) @(posedge aclk);
			chk("irq", irq, 1'h0);
		end
		wr(`UACT_ER_ADDR, 32'h00);
		pulse_cts();
		chk("irq", irq, 1'h0);
		rdc(`UACT_MSR_ADDR, msr(4'h1, 4'h0));
		// transmit withheld while cts high, stall after current char
		b = 8'($urandom);
		b2 = 8'($urandom);
		wr(`UACT_RBR_ADDR, {24'h0, b});
		wr(`UACT_RBR_ADDR, {24'h0, b2});
		repeat (30 * BC) begin
			@(posedge aclk);
			chk("txd held", txd, 1'h1);
		end
		chk("rx count", rx_cnt, 1);
		hold <= 1'h0;
		repeat (3 * BC) @(posedge aclk);
		hold <= 1'h1;
		wait_rx(2);
		chk("rx byte", rx_byte, b);
		repeat (30 * BC) begin
			@(posedge aclk);
			chk("txd stall", txd, 1'h1);
		end
		chk("rx count", rx_cnt, 2);
		hold <= 1'h0;
		wait_rx(3);
		chk("rx byte", rx_byte, b2);
		chk("framing", bad_cnt, 0);
		// receive fifo: fill, overrun, drain
		wr(`UACT_FCR_ADDR, 32'h01);
		for (int i = 0; i <= DP; i++) begin
			b = 8'($urandom);
			push(b, 1'h0);
			if (i < DP) q.push_back(b);
		end
		rdc(`UACT_LSR_ADDR, lsr(1'h1, 1'h1, 1'h0));
		rdc(`UACT_LSR_ADDR, lsr(1'h1, 1'h0, 1'h0));
		foreach (q[i]) rdc(`UACT_RBR_ADDR, {24'h0, q[i]});
		rdc(`UACT_LSR_ADDR, 32'h0);
		rdc(`UACT_RBR_ADDR, 32'h0);
		b = 8'($urandom);
		push(b, 1'h1);
		repeat (3) @(posedge aclk);
		rdc(`UACT_LSR_ADDR, lsr(1'h1, 1'h0, 1'h1));
		rdc(`UACT_LSR_ADDR, lsr(1'h1, 1'h0, 1'h0));
		rdc(`UACT_RBR_ADDR, {24'h0, b});
		// single holding buffer: second char overruns
		wr(`UACT_FCR_ADDR, 32'h00);
		push(b, 1'h1);
		push(8'($urandom), 1'h0);
		rdc(`UACT_LSR_ADDR, lsr(1'h1, 1'h1, 1'h1));
		rdc(`UACT_RBR_ADDR, {24'h0, b});
		end_of_test();
	end
endmodule : tb_top
